/* shared/rac_pkg.sv */
`default_nettype none
package rac_pkg;
  // bus map (byte addresses)
  localparam logic [7:0]  RAC_MISC_OFS     = 8'h0c;
  localparam logic [7:0]  RAC_STAT_OFS     = 8'h10;
  // control register bit positions
  localparam int          RAC_B_POR        = 7;
  localparam int          RAC_B_POS        = 6;
  localparam int          RAC_B_NEG        = 5;
  localparam int          RAC_B_EXTEN      = 4;
  localparam int          RAC_B_FSA        = 3;
  localparam int          RAC_B_FSB        = 2;
  localparam int          RAC_B_SLOW       = 1;
  localparam int          RAC_B_WATCHDOG_ENABLE_BIT       = 0;
  // watchdog enable default after reset or stop (fixed option)
  localparam logic        RAC_WATCHDOG_ENABLE_BIT_DFLT    = 1'b0;
  // vectors and reset loads
  localparam logic [15:0] RAC_VEC_RESET    = 16'h3ffe;
  localparam logic [15:0] RAC_TMR_LOAD     = 16'hfffc;
  localparam logic [15:0] RAC_SP_LOAD      = 16'h00ff;
  // oscillator start-up hold, in clock cycles
  localparam logic [11:0] RAC_OSC_DLY_CYC  = 12'hfe0;
  // service source codes, vector = reset vector - 2 * code
  localparam logic [2:0]  RAC_SRC_RESET    = 3'h0;
  localparam logic [2:0]  RAC_SRC_SWI      = 3'h1;
  localparam logic [2:0]  RAC_SRC_EXT      = 3'h2;
  // pin synchroniser: bits 8:0 wired-or pins, bit 9 irq pin (active low)
  localparam int          RAC_NPIN         = 10;
  localparam int          RAC_NHW          = 6;

  typedef enum logic [1:0] {
    RAC_RUN  = 2'b00,
    RAC_PUSH = 2'b01,
    RAC_VECT = 2'b10
  } rac_phase_t;

  typedef struct packed {
    rac_phase_t              phase;
    logic [2:0]              src;
    logic                    mask;
    logic [7:0]              misc;
    logic [RAC_NPIN-1:0]     s1;
    logic [RAC_NPIN-1:0]     s2;
    logic [RAC_NPIN-1:0]     s3;
    logic [RAC_NPIN-1:0]     filt;
    logic                    comb_prev;
    logic                    ext_latch;
    logic                    swi_pend;
    logic [RAC_NHW-1:0]      snap;
    logic                    stop_latch;
    logic                    wait_latch;
    logic [11:0]             osc_cnt;
    logic                    ack;
    logic [7:0]              rdata;
    logic [15:0]             vector;
    logic                    vec_valid;
    logic                    push;
    logic                    reset_fx;
    logic                    cold_fx;
    logic                    stop_fx;
    logic                    watchdog_enable_bit_clr;
  } rac_state_t;
endpackage
`default_nettype wire

/* logic/rac_top.sv */
// Notes on behaviour
// RULE1 - requests wait for instruction completion
// RULE2 - serve only if unmasked and enabled
// RULE3 - push registers, then set mask
// RULE4 - return restores mask from stack
// RULE5 - fixed priority, vectors descend by two
// RULE6 - soft trap ignores mask, after earlier requests
// RULE7 - mask holds off all maskable requests
// RULE8 - external latch cleared at service entry
// RULE9 - sensitivity bits writable only while masked
// RULE10 - resets clear both sensitivity bits
// RULE11 - four sensitivity encodings for combined input
// RULE12 - resets clear prescaler, load counter, disables
// RULE13 - resets clear ports, stack, latches, vector
// RULE14 - wait and stop clear the mask
// RULE15 - power-on flag set only by power-on
// RULE16 - resets disable serial unit, set tx flags
// RULE17 - power-on and stop hold oscillator off
// RULE18 - resets and stop disable converter, slow mode
// RULE19 - all four events clear watchdog counter
// RULE20 - resets and stop restore watchdog enable default
// RULE21 - resets clear enables but set external enable
// RULE22 - all external pins share one vector
// RULE23 - combine pins before sensitivity selection
// RULE24 - changing sensitivity drops pending external request
// RULE25 - disabled external edges still latched
`default_nettype none
module rac_top
  import rac_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        irq_n_pin_i,
  input  wire logic [7:0]  wired_or_wake_input_i,
  input  wire logic        dedicated_wired_or_pin_i,
  input  wire logic [8:0]  wired_or_en_i,
  input  wire logic [4:0]  periph_req_i,
  input  wire logic [4:0]  periph_en_i,
  input  wire logic        instr_done_i,
  input  wire logic        soft_trap_fetch_i,
  input  wire logic        return_from_trap_i,
  input  wire logic        stacked_mask_i,
  input  wire logic        wait_exec_i,
  input  wire logic        stop_exec_i,
  input  wire logic        ext_reset_i,
  input  wire logic        por_i,
  output logic             irq_mask_bit_o,
  output logic             stack_push_o,
  output logic [15:0]      vector_o,
  output logic             vector_valid_o,
  output logic             addr_restart_o,
  output logic             timer_presc_clr_o,
  output logic             timer_cnt_load_o,
  output logic [15:0]      timer_load_value_o,
  output logic             timer_en_clr_o,
  output logic             ddr_clr_o,
  output logic             sp_load_o,
  output logic [15:0]      sp_value_o,
  output logic             sci_disable_o,
  output logic             sci_ie_clr_o,
  output logic             sci_status_clr_o,
  output logic             sci_tx_flags_set_o,
  output logic             osc_off_o,
  output logic             timer_clk_clr_o,
  output logic             sci_clk_clr_o,
  output logic             adc_disable_o,
  output logic             watchdog_enable_bit_cnt_clr_o,
  output logic             watchdog_enable_bit_o,
  output logic             slow_mode_bit_o,
  output logic             freq_select_a_o,
  output logic             freq_select_b_o,
  output logic             stop_latch_o,
  output logic             wait_latch_o
);

  rac_state_t q;
  rac_state_t d;

  logic                combined_ext_irq;
  logic                ext_rise;
  logic                ext_fall;
  logic                ext_edge;
  logic                ext_level;
  logic [RAC_NHW-1:0]  hw_req;
  logic                bus_req;
  logic                wr_misc;
  logic                any_reset;
  logic [7:0]          wbyte;

  // first priority hit, lowest index wins
  function automatic logic [2:0] rac_pick(input logic [RAC_NHW-1:0] v);
    logic [2:0] r;
    r = RAC_SRC_EXT;
    for (int i = RAC_NHW - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(RAC_SRC_EXT + 3'(i));
      end
    end
    return r;
  endfunction

  // wired-or pins high, irq pin low; sensitivity applies afterwards
  assign combined_ext_irq = |(q.filt[8:0] & wired_or_en_i) | ~q.filt[9]; // [RULE23] [RULE22]
  assign ext_rise  = combined_ext_irq & ~q.comb_prev;
  assign ext_fall  = ~combined_ext_irq & q.comb_prev;

  always_comb begin
    unique case ({q.misc[RAC_B_POS], q.misc[RAC_B_NEG]}) // [RULE11]
      2'b00:   ext_edge = ext_rise;
      2'b01:   ext_edge = ext_rise;
      2'b10:   ext_edge = ext_fall;
      2'b11:   ext_edge = ext_rise | ext_fall;
    endcase
  end

  // only the default encoding is level sensitive, and the level is not latched
  assign ext_level = combined_ext_irq & ~q.misc[RAC_B_POS] & ~q.misc[RAC_B_NEG];

  assign hw_req = {periph_req_i & periph_en_i,
                   q.misc[RAC_B_EXTEN] & (q.ext_latch | ext_level)}; // [RULE2] [RULE5]

  assign bus_req   = wb_cyc_i & wb_stb_i & ~q.ack;
  // a write lands on the edge that sees ack high, so an abandoned cycle writes nothing
  assign wr_misc   = wb_cyc_i & wb_stb_i & q.ack & wb_we_i & wb_sel_i[0]
                     & (wb_adr_i[7:2] == RAC_MISC_OFS[7:2]);
  assign any_reset = por_i | ext_reset_i;
  assign wbyte     = wb_dat_i[7:0];

  always_comb begin
    d           = q;
    d.vec_valid = 1'b0;
    d.push      = 1'b0;
    d.reset_fx  = 1'b0;
    d.cold_fx   = 1'b0;
    d.stop_fx   = 1'b0;
    d.watchdog_enable_bit_clr  = 1'b0;

    // three-stage synchroniser; a change counts once stages two and three agree
    d.s1 = {~irq_n_pin_i ^ 1'b1, dedicated_wired_or_pin_i, wired_or_wake_input_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < RAC_NPIN; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.filt[i] = q.s3[i];
      end
    end
    d.comb_prev = combined_ext_irq;

    if (q.osc_cnt != 12'h000) begin
      d.osc_cnt = q.osc_cnt - 12'h001;
    end

    // wishbone slave, one wait state
    d.ack = bus_req;
    if (bus_req) begin
      unique case (wb_adr_i[7:2])
        RAC_MISC_OFS[7:2]: d.rdata = q.misc;
        RAC_STAT_OFS[7:2]: d.rdata = {q.phase, q.mask, q.ext_latch, (q.osc_cnt != 12'h000),
                                      q.stop_latch, q.wait_latch, q.swi_pend};
        default:           d.rdata = 8'h00;
      endcase
    end

    if (wr_misc) begin
      if (!wbyte[RAC_B_POR]) begin
        d.misc[RAC_B_POR] = 1'b0;
      end
      if (q.mask) begin
        d.misc[RAC_B_POS]   = wbyte[RAC_B_POS]; // [RULE9]
        d.misc[RAC_B_NEG]   = wbyte[RAC_B_NEG]; // [RULE9]
        d.misc[RAC_B_EXTEN] = wbyte[RAC_B_EXTEN];
        if (wbyte[RAC_B_POS] != q.misc[RAC_B_POS] || wbyte[RAC_B_NEG] != q.misc[RAC_B_NEG]) begin
          d.ext_latch = 1'b0; // [RULE24]
        end
      end
      d.misc[RAC_B_FSA]  = wbyte[RAC_B_FSA];
      d.misc[RAC_B_FSB]  = wbyte[RAC_B_FSB];
      d.misc[RAC_B_SLOW] = wbyte[RAC_B_SLOW];
      // enable is one-way; writing one also restarts the counter
      if (wbyte[RAC_B_WATCHDOG_ENABLE_BIT]) begin
        d.misc[RAC_B_WATCHDOG_ENABLE_BIT] = 1'b1;
        d.watchdog_enable_bit_clr         = 1'b1;
      end
    end

    if (soft_trap_fetch_i) begin
      d.swi_pend = 1'b1;
      d.snap     = hw_req; // [RULE6]
    end

    unique case (q.phase)
      RAC_RUN: begin
        // only at a boundary; the running instruction is never cut short
        if (instr_done_i) begin // [RULE1]
          if (q.swi_pend) begin
            if (!q.mask && |(hw_req & q.snap)) begin // [RULE6]
              d.src   = rac_pick(hw_req & q.snap);
              d.phase = RAC_PUSH;
            end else begin
              d.src      = RAC_SRC_SWI; // [RULE6]
              d.swi_pend = soft_trap_fetch_i;
              d.phase    = RAC_PUSH;
            end
          end else if (!q.mask && |hw_req) begin // [RULE2] [RULE7]
            d.src   = rac_pick(hw_req); // [RULE5]
            d.phase = RAC_PUSH;
          end
        end
        if (return_from_trap_i) begin
          d.mask = stacked_mask_i; // [RULE4]
        end
      end
      RAC_PUSH: begin
        d.push  = 1'b1; // [RULE3]
        d.phase = RAC_VECT;
        if (q.src == RAC_SRC_EXT) begin
          d.ext_latch = 1'b0; // [RULE8]
        end
      end
      RAC_VECT: begin
        d.mask       = 1'b1; // [RULE3]
        d.vector     = RAC_VEC_RESET - {12'h000, q.src, 1'b0}; // [RULE5]
        d.vec_valid  = 1'b1;
        d.stop_latch = 1'b0;
        d.wait_latch = 1'b0;
        d.phase      = RAC_RUN;
      end
      default: d.phase = RAC_RUN;
    endcase

    // edge captured whatever the enable; a new edge beats any clear above
    if (ext_edge) begin
      d.ext_latch = 1'b1; // [RULE25]
    end

    if (wait_exec_i) begin
      d.mask       = 1'b0; // [RULE14]
      d.wait_latch = 1'b1;
      d.watchdog_enable_bit_clr   = 1'b1; // [RULE19]
    end
    if (stop_exec_i) begin
      d.mask             = 1'b0; // [RULE14]
      d.stop_latch       = 1'b1;
      d.stop_fx          = 1'b1;
      d.osc_cnt          = RAC_OSC_DLY_CYC; // [RULE17]
      d.misc[RAC_B_SLOW] = 1'b0; // [RULE18]
      d.misc[RAC_B_WATCHDOG_ENABLE_BIT] = RAC_WATCHDOG_ENABLE_BIT_DFLT; // [RULE20]
      d.watchdog_enable_bit_clr         = 1'b1; // [RULE19]
    end

    // resets override what they assign in the same cycle; a stop's stop_fx and osc_cnt load survive an external reset
    if (any_reset) begin
      d.reset_fx    = 1'b1; // [RULE12] [RULE16]
      d.watchdog_enable_bit_clr    = 1'b1; // [RULE19]
      d.mask        = 1'b1; // [RULE13] [RULE14]
      d.stop_latch  = 1'b0; // [RULE13]
      d.wait_latch  = 1'b0;
      d.ext_latch   = 1'b0;
      d.swi_pend    = 1'b0;
      d.src         = RAC_SRC_RESET;
      d.phase       = RAC_VECT; // [RULE13]
      d.misc[6:0]   = {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, RAC_WATCHDOG_ENABLE_BIT_DFLT}; // [RULE10] [RULE21] [RULE18] [RULE20]
      if (por_i) begin
        d.misc[RAC_B_POR] = 1'b1; // [RULE15]
        d.cold_fx         = 1'b1;
        d.osc_cnt         = RAC_OSC_DLY_CYC; // [RULE17]
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q            <= '0;
      q.phase      <= RAC_VECT;
      q.src        <= RAC_SRC_RESET;
      q.mask       <= 1'b1;
      q.misc       <= {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, RAC_WATCHDOG_ENABLE_BIT_DFLT};
      q.s1         <= {RAC_NPIN{1'b0}} | 10'h200;
      q.s2         <= 10'h200;
      q.s3         <= 10'h200;
      q.filt       <= 10'h200;
      q.osc_cnt    <= RAC_OSC_DLY_CYC;
      q.reset_fx   <= 1'b1;
      q.cold_fx    <= 1'b1;
      q.watchdog_enable_bit_clr   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o              = {24'h000000, q.rdata};
  assign wb_ack_o              = q.ack;
  assign irq_mask_bit_o        = q.mask;
  assign stack_push_o          = q.push;
  assign vector_o              = q.vector;
  assign vector_valid_o        = q.vec_valid;
  assign addr_restart_o        = q.reset_fx; // [RULE13]
  assign timer_presc_clr_o     = q.reset_fx; // [RULE12]
  assign timer_cnt_load_o      = q.reset_fx;
  assign timer_load_value_o    = RAC_TMR_LOAD;
  assign timer_en_clr_o        = q.reset_fx;
  assign ddr_clr_o             = q.reset_fx; // [RULE13]
  assign sp_load_o             = q.reset_fx;
  assign sp_value_o            = RAC_SP_LOAD;
  assign sci_disable_o         = q.reset_fx; // [RULE16]
  assign sci_ie_clr_o          = q.reset_fx;
  assign sci_status_clr_o      = q.reset_fx;
  assign sci_tx_flags_set_o    = q.reset_fx;
  assign osc_off_o             = q.osc_cnt != 12'h000; // [RULE17]
  assign timer_clk_clr_o       = q.cold_fx | q.stop_fx; // [RULE17]
  assign sci_clk_clr_o         = q.cold_fx | q.stop_fx;
  assign adc_disable_o         = q.reset_fx | q.stop_fx; // [RULE18]
  assign watchdog_enable_bit_cnt_clr_o        = q.watchdog_enable_bit_clr;
  assign watchdog_enable_bit_o = q.misc[RAC_B_WATCHDOG_ENABLE_BIT];
  assign slow_mode_bit_o       = q.misc[RAC_B_SLOW];
  assign freq_select_a_o       = q.misc[RAC_B_FSA];
  assign freq_select_b_o       = q.misc[RAC_B_FSB];
  assign stop_latch_o          = q.stop_latch;
  assign wait_latch_o          = q.wait_latch;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  logic quiet;
  assign quiet = ~any_reset & ~wait_exec_i & ~stop_exec_i;

  sequence s_entry;
    q.phase == RAC_PUSH ##1 q.phase == RAC_VECT && stack_push_o;
  endsequence

  sequence s_reset_vec;
    q.phase == RAC_VECT ##1 vector_valid_o && vector_o == RAC_VEC_RESET && irq_mask_bit_o;
  endsequence

  chk_entry_at_boundary: assert property ( // [RULE1]
    $rose(q.phase == RAC_PUSH) |-> $past(instr_done_i))
    else $error("service entered without instruction completion");

  chk_push_then_mask: assert property ( // [RULE3]
    (q.phase == RAC_RUN && instr_done_i && !q.mask && |hw_req && quiet && !q.swi_pend)
      |=> s_entry ##1 irq_mask_bit_o && vector_valid_o)
    else $error("push and mask order broken");

  chk_mask_holds_off: assert property ( // [RULE7]
    (q.phase == RAC_RUN && q.mask && instr_done_i && !q.swi_pend && quiet) |=> q.phase == RAC_RUN)
    else $error("masked request was serviced");

  chk_return_mask: assert property ( // [RULE4]
    (q.phase == RAC_RUN && return_from_trap_i && quiet) |=> irq_mask_bit_o == $past(stacked_mask_i))
    else $error("return did not restore mask");

  chk_sel_locked: assert property ( // [RULE9]
    (wr_misc && !q.mask && !any_reset) |=> $stable(q.misc[RAC_B_POS:RAC_B_NEG]))
    else $error("sensitivity changed while unmasked");

  chk_reset_vector: assert property ( // [RULE13]
    any_reset |=> s_reset_vec)
    else $error("reset did not vector through reset vector");

  chk_wait_mask: assert property ( // [RULE14]
    (wait_exec_i && !any_reset) |=> !irq_mask_bit_o && watchdog_enable_bit_cnt_clr_o)
    else $error("wait did not clear mask");

  chk_por_flag_src: assert property ( // [RULE15]
    (!por_i && !q.misc[RAC_B_POR]) |=> !q.misc[RAC_B_POR])
    else $error("power-on flag set without power-on");

  chk_osc_hold: assert property ( // [RULE17]
    por_i |=> osc_off_o [*8])
    else $error("oscillator hold too short");

  chk_ext_latch_drop: assert property ( // [RULE8]
    (q.phase == RAC_PUSH && q.src == RAC_SRC_EXT && !ext_edge && !any_reset) |=> !q.ext_latch)
    else $error("external latch not cleared at entry");

  chk_reset_effects: assert property ( // [RULE12]
    any_reset |=> timer_presc_clr_o && timer_cnt_load_o && sci_tx_flags_set_o && adc_disable_o)
    else $error("reset effects missing");

endmodule
`default_nettype wire

/* verification/rac_cpu_model.sv */
`default_nettype none
module rac_cpu_model (
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic [3:0] gap_i,
  input  wire logic       push_i,
  input  wire logic       vec_i,
  output logic            instr_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic       hold_q;
  // a real sequencer has no boundary between stacking and the vector fetch
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q        <= 4'h0;
      hold_q       <= 1'b0;
      instr_done_o <= 1'b0;
    end else begin
      hold_q       <= (hold_q | push_i) & ~vec_i;
      instr_done_o <= 1'b0;
      if (cnt_q >= gap_i) begin
        cnt_q        <= 4'h0;
        instr_done_o <= ~hold_q & ~push_i;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
`default_nettype none
module tb
  import rac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, irq_n = 1'b1, dwo = 1'b0, stk = 1'b0;
  logic [7:0]  adr = 8'h00, wired_or_wake_input = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rs = 32'd12499;
  logic [8:0]  wo_en = 9'h000;
  logic [4:0]  req = 5'h00, en = 5'h00;
  logic [5:0]  ev = 6'h00;
  logic [3:0]  gap = 4'h2, sel = 4'h0;
  logic [15:0] vec, tval, spval;
  logic [9:0]  fx;
  logic        ack, done, mask, push, vval, osc, tclk, sclk, adc, wclr, watchdog_enable_bit, slow;
  logic        fsa, fsb, stl, wtl;
  logic [15:0] vq[$];
  logic [31:0] rq[$];
  int          err_count = 0, compares = 0, cyc_n = 0, pushes = 0, nsrv = 0, n;

  always #5 mclk_i = ~mclk_i;

  rac_top uut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_n_pin_i(irq_n), .wired_or_wake_input_i(wired_or_wake_input), .dedicated_wired_or_pin_i(dwo),
    .wired_or_en_i(wo_en), .periph_req_i(req), .periph_en_i(en), .instr_done_i(done),
    .soft_trap_fetch_i(ev[5]), .return_from_trap_i(ev[0]), .stacked_mask_i(stk),
    .wait_exec_i(ev[1]), .stop_exec_i(ev[2]), .ext_reset_i(ev[3]), .por_i(ev[4]),
    .irq_mask_bit_o(mask), .stack_push_o(push), .vector_o(vec), .vector_valid_o(vval),
    .addr_restart_o(fx[0]), .timer_presc_clr_o(fx[1]), .timer_cnt_load_o(fx[2]),
    .timer_load_value_o(tval), .timer_en_clr_o(fx[3]), .ddr_clr_o(fx[4]),
    .sp_load_o(fx[5]), .sp_value_o(spval), .sci_disable_o(fx[6]), .sci_ie_clr_o(fx[7]),
    .sci_status_clr_o(fx[8]), .sci_tx_flags_set_o(fx[9]), .osc_off_o(osc),
    .timer_clk_clr_o(tclk), .sci_clk_clr_o(sclk), .adc_disable_o(adc),
    .watchdog_enable_bit_cnt_clr_o(wclr), .watchdog_enable_bit_o(watchdog_enable_bit), .slow_mode_bit_o(slow),
    .freq_select_a_o(fsa), .freq_select_b_o(fsb), .stop_latch_o(stl), .wait_latch_o(wtl)
  );

  rac_cpu_model cpu (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .gap_i(gap), .push_i(push), .vec_i(vval),
    .instr_done_o(done)
  );

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wrap_up();
    chk(32'h0, 32'(vq.size() + rq.size()));
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // no local limit: only the cycle ceiling ends a wait for ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask

  // returns where the registered effects of the pulse are visible
  task automatic pulse(input int i);
    @(posedge mclk_i);
    ev[i] <= 1'b1;
    @(posedge mclk_i);
    ev[i] <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic want(input logic [15:0] v);
    vq.push_back(v);
    if (v != RAC_VEC_RESET) nsrv++;
  endtask

  // quiet tail: any vector here with nothing noted is flagged
  task automatic settle();
    n = 0;
    while (vq.size() != 0 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (20) @(posedge mclk_i);
  endtask

  task automatic edge_irq();
    irq_n <= 1'b0;
    repeat (8) @(posedge mclk_i);
    irq_n <= 1'b1;
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic osc_len();
    n = 0;
    while (osc === 1'b1 && n < 5000) begin
      n++;
      @(posedge mclk_i);
    end
    chk(32'd4064, 32'(n));
  endtask

  always @(posedge mclk_i) begin
    cyc_n++;
    if (push === 1'b1) pushes++;
    if (ack === 1'b1 && we === 1'b0) begin
      chk(rq.size() != 0 ? rq.pop_front() : 32'hdead_beef, rdat);
    end
    if (vval === 1'b1) begin
      chk(vq.size() != 0 ? {16'h0, vq.pop_front()} : 32'hffff_ffff, {16'h0, vec});
      chk(32'h1, 32'(mask));
    end
    if (cyc_n == 40000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    want(RAC_VEC_RESET);
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(RAC_MISC_OFS, 8'h90);
    chk(32'h1, 32'(mask));
    rd(8'h20, 8'h00);
    for (int r = 0; r < 3; r++) begin
      logic [31:0] x;
      x = xs();
      gap <= x[13:10];
      req <= x[4:0];
      en <= x[9:5];
      repeat (20) @(posedge mclk_i);
      for (int i = 0; i < 5; i++) begin
        if (x[i] & x[5+i]) begin
          want(16'h3ff8 - 16'(2 * i));
          pulse(0);
          settle();
          req[i] <= 1'b0;
        end
      end
      pulse(0);
      repeat (20) @(posedge mclk_i);
      req <= 5'h00;
      want(16'h3ffc);
      pulse(5);
      settle();
    end
    want(16'h3ffc);
    pulse(5);
    settle();
    pulse(0);
    // request rising just after the trap fetch must wait behind the trap
    want(16'h3ffc);
    ev[5] <= 1'b1;
    @(posedge mclk_i);
    ev[5] <= 1'b0;
    req <= 5'h01;
    en <= 5'h01;
    settle();
    want(16'h3ff8);
    pulse(0);
    settle();
    req <= 5'h00;
    pulse(0);
    chk(32'h0, 32'(mask));
    stk <= 1'b1;
    pulse(0);
    chk(32'h1, 32'(mask));
    stk <= 1'b0;
    bus(1'b1, RAC_MISC_OFS, 8'hb0);
    rd(RAC_MISC_OFS, 8'hb0);
    edge_irq();
    want(16'h3ffa);
    pulse(0);
    settle();
    pulse(0);
    repeat (30) @(posedge mclk_i);
    bus(1'b1, RAC_MISC_OFS, 8'hd0);
    rd(RAC_MISC_OFS, 8'hb0);
    want(16'h3ffc);
    pulse(5);
    settle();
    edge_irq();
    bus(1'b1, RAC_MISC_OFS, 8'hd0);
    rd(RAC_MISC_OFS, 8'hd0);
    pulse(0);
    repeat (30) @(posedge mclk_i);
    want(16'h3ffc);
    pulse(5);
    settle();
    bus(1'b1, RAC_MISC_OFS, 8'hc0);
    wo_en <= 9'h100;
    dwo <= 1'b1;
    repeat (8) @(posedge mclk_i);
    dwo <= 1'b0;
    repeat (30) @(posedge mclk_i);
    bus(1'b1, RAC_MISC_OFS, 8'hd0);
    want(16'h3ffa);
    pulse(0);
    settle();
    bus(1'b1, RAC_MISC_OFS, 8'hdf);
    rd(RAC_MISC_OFS, 8'hdf);
    // the power-up hold must be over first, or wait could not be told apart from it
    while (osc !== 1'b0) begin
      @(posedge mclk_i);
    end
    pulse(1);
    chk(32'h07, 32'({mask, osc, slow, watchdog_enable_bit, wclr}));
    chk(32'h0e, 32'({fsa, fsb, wtl, stl}));
    pulse(2);
    chk(32'h0f, 32'({mask, slow, watchdog_enable_bit, wclr, tclk, sclk, adc}));
    chk(32'h3, 32'({stl, wtl}));
    osc_len();
    rd(RAC_STAT_OFS, 8'h06);
    bus(1'b1, RAC_MISC_OFS, 8'h00);
    rd(RAC_MISC_OFS, 8'h50);
    want(RAC_VEC_RESET);
    pulse(3);
    chk(32'h3ff, {22'h0, fx});
    chk({RAC_TMR_LOAD, RAC_SP_LOAD}, {tval, spval});
    chk(32'ha, 32'({mask, osc, adc, tclk}));
    chk(32'h0, 32'({stl, wtl, fsa, fsb}));
    rd(RAC_MISC_OFS, 8'h10);
    want(RAC_VEC_RESET);
    pulse(4);
    osc_len();
    rd(RAC_MISC_OFS, 8'h90);
    settle();
    chk(32'(nsrv), 32'(pushes));
    wrap_up();
  end
endmodule
`default_nettype wire
